// ===== design/stkx_pkg.sv
/*
 * Constants for the stack push/pop execution block: register offsets,
 * field positions, reset values, opcodes and sequencer states.
 * Assumes a 16-bit big-endian storage word and 16-bit general registers.
 */
`default_nettype none
package stkx_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_INSTR = 8'h04;
    localparam logic [7:0] A_EADDR = 8'h08;
    localparam logic [7:0] A_IADDR = 8'h0C;
    localparam logic [7:0] A_LIMIT = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;
    localparam logic [7:0] A_IND = 8'h18;
    localparam logic [7:0] A_GPR = 8'h20;
    localparam int F_START = 0;
    localparam int F_INDIR = 1;
    localparam int F_OP = 4;
    localparam int F_R = 8;
    localparam int F_RB = 6;
    localparam int F_AM = 4;
    localparam int F_DIR = 3;
    localparam int I_ZERO = 0;
    localparam int I_NEG = 1;
    localparam int I_EVEN = 2;
    localparam int I_OVF = 3;
    localparam int I_CARRY = 4;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [15:0] BASE_STEP = 16'h0002;
    localparam logic [15:0] SCB_HI_OFS = 16'h0000;
    localparam logic [15:0] SCB_LO_OFS = 16'h0002;
    localparam logic [15:0] SCB_TOP_OFS = 16'h0004;
    localparam logic [15:0] SCB_SPAN = 16'h0005;
    localparam logic [15:0] LIMIT_RST = 16'hFFFF;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [2:0] {
        or_imm_op = 3'h0, pop_byte_op = 3'h1, pop_word_op = 3'h2,
        pop_doubleword_op = 3'h3, push_byte_op = 3'h4, push_word_op = 3'h5,
        push_doubleword_op = 3'h6, reset_bits_byte_op = 3'h7
    } stkx_op_e;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_CHK = 4'h1, S_SCB_TOP = 4'h2, S_SCB_LIM = 4'h3,
        S_STK = 4'h4, S_RD0 = 4'h5, S_RD1 = 4'h6, S_WR0 = 4'h7, S_WR1 = 4'h8,
        S_TOP_WR = 4'h9, S_OR_RD = 4'hA, S_OR_WR = 4'hB, S_RB_RD = 4'hC,
        S_RB_WR = 4'hD, S_FIN = 4'hE
    } stkx_st_e;
endpackage
`default_nettype wire

// ===== design/stkx_chk.sv
/*
 * Storage address check: range against installed storage, odd boundary.
 * Assumes limit is the highest installed byte address.
 */
`timescale 1ns/1ps
`default_nettype none
module stkx_chk (
    input wire logic [15:0] addr,
    input wire logic [15:0] span,
    input wire logic [15:0] limit,
    input wire logic even_req,
    output logic inv,
    output logic odd
);
    // 17 bits so an operand wrapping past the top is caught
    assign inv = ({1'b0, addr} + {1'b0, span}) > {1'b0, limit};
    assign odd = even_req & addr[0];
endmodule
`default_nettype wire

// ===== design/stkx_mem.sv
/*
 * One storage access at a time: request held until acknowledge.
 * Assumes the storage answers each request with a one-cycle ack.
 */
`timescale 1ns/1ps
`default_nettype none
module stkx_mem (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [1:0] be,
    input wire logic [15:0] wdata,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [1:0] mem_be,
    output logic [15:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic done,
    output logic [15:0] rdata
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 16'h0000;
            mem_be <= 2'h0;
            mem_wdata <= 16'h0000;
            done <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            done <= mem_req & mem_ack;
            if (go & !mem_req) begin
                mem_req <= 1'b1;
                mem_we <= we;
                mem_addr <= addr;
                mem_be <= be;
                mem_wdata <= wdata;
            end else if (mem_req & mem_ack) begin
                mem_req <= 1'b0;
                rdata <= mem_rdata;
            end
        end
    end
endmodule
`default_nettype wire

// ===== design/stkx_top.sv
/*
 * Stack push/pop execution with storage-immediate OR and reset-bits-byte,
 * register file and instruction registers behind an AHB-Lite slave.
 * Assumes software supplies the effective address and indirect address.
 */
// Chosen here: the register addresses and register access over AHB-Lite.
// Functional notes
// RULE1 - OR immediate word into storage word at effective address, write back
// RULE2 - software keeps instruction bits 5 to 7 zero on OR immediate
// RULE3 - OR immediate keeps carry, overflow; sets even, negative, zero
// RULE4 - OR immediate: odd indirect or operand address gives specification check
// RULE5 - pop byte loads top byte into register low byte
// RULE6 - pop doubleword loads pair R, R+1; R=7 uses 7 and 0
// RULE7 - pop word loads top word into selected register
// RULE8 - push byte pushes register low byte
// RULE9 - push doubleword pushes pair R, R+1; R=7 uses 7 and 0
// RULE10 - push word pushes the whole 16-bit register
// RULE11 - stack control block sits at the effective address
// RULE12 - address mode 01 adds two to selected base register
// RULE13 - pop from empty stack raises stack exception trap
// RULE14 - push onto full stack raises stack exception trap
// RULE15 - base register still incremented on stack exception
// RULE16 - push and pop leave all indicators unchanged
// RULE17 - instruction, control block or operand outside storage: invalid address
// RULE18 - odd indirect, control block or element address: specification check
// RULE19 - reset-bits-byte direction 0 storage to register, 1 register to storage
// RULE20 - direction select is instruction bit 12
// RULE21 - storage to register clears low byte bits set in storage byte
// RULE22 - stack exception leaves register, stack, control block unchanged
`timescale 1ns/1ps
`default_nettype none
module stkx_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [1:0] mem_be,
    output logic [15:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic busy,
    output logic soft_trap,
    output logic prog_check
);
    import stkx_pkg::*;

    stkx_st_e st_ff, nxt_st;
    stkx_op_e op_ff;
    logic indf_ff, wr_ff, done_ff, stk_ff, inv_ff, spec_ff;
    logic [7:0] wa_ff;
    logic [15:0] instr_ff, imm_ff, ea_ff, inda_ff, iaddr_ff, limit_ff;
    logic [15:0] top_ff, lim_ff, dhi_ff, dlo_ff;
    logic [4:0] ind_ff;
    logic [15:0] gpr_ff [8];
    logic [31:0] hrdata_ff;
    logic busy_ff, trap_ff, pchk_ff;

    // bus side
    wire acc = hsel & htrans[1] & hready;
    wire in_map = haddr[31:8] == 24'h0;
    wire is_gpr = haddr[7:5] == A_GPR[7:5];
    wire [31:0] rd_val = !in_map ? 32'h0 :
        is_gpr ? {16'h0, gpr_ff[haddr[4:2]]} :
        haddr[7:0] == A_CTRL ? {25'h0, op_ff, 2'h0, indf_ff, 1'b0} :
        haddr[7:0] == A_INSTR ? {imm_ff, instr_ff} :
        haddr[7:0] == A_EADDR ? {inda_ff, ea_ff} :
        haddr[7:0] == A_IADDR ? {16'h0, iaddr_ff} :
        haddr[7:0] == A_LIMIT ? {16'h0, limit_ff} :
        haddr[7:0] == A_STAT ? {27'h0, spec_ff, inv_ff, stk_ff, done_ff, busy_ff} :
        haddr[7:0] == A_IND ? {27'h0, ind_ff} : 32'h0;
    // software writes are dropped while an instruction runs
    wire sw = wr_ff & !busy_ff;
    wire sw_ctrl = sw & wa_ff == A_CTRL;
    wire sw_gpr = sw & wa_ff[7:5] == A_GPR[7:5];
    wire start = sw_ctrl & hwdata[F_START];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            wa_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            wr_ff <= acc & hwrite & in_map & hsize == HSIZE_WORD;
            wa_ff <= haddr[7:0];
            if (acc & !hwrite) hrdata_ff <= rd_val;
        end
    end
    assign hrdata = hrdata_ff;

    // zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_ff <= or_imm_op;
            indf_ff <= 1'b0;
            instr_ff <= 16'h0000;
            imm_ff <= 16'h0000;
            ea_ff <= 16'h0000;
            inda_ff <= 16'h0000;
            iaddr_ff <= 16'h0000;
            limit_ff <= LIMIT_RST;
        end else if (sw) begin
            if (wa_ff == A_CTRL) op_ff <= stkx_op_e'(hwdata[F_OP+2:F_OP]);
            if (wa_ff == A_CTRL) indf_ff <= hwdata[F_INDIR];
            if (wa_ff == A_INSTR) {imm_ff, instr_ff} <= hwdata;
            if (wa_ff == A_EADDR) {inda_ff, ea_ff} <= hwdata;
            if (wa_ff == A_IADDR) iaddr_ff <= hwdata[15:0];
            if (wa_ff == A_LIMIT) limit_ff <= hwdata[15:0];
        end
    end

    // instruction fields, bit 0 is the most significant
    wire [2:0] r_f = instr_ff[F_R+2:F_R];
    wire [2:0] r_n = r_f + 3'h1; // RULE6 RULE9
    wire [2:0] rb_f = {1'b0, instr_ff[F_RB+1:F_RB]};
    wire am_inc = instr_ff[F_AM+1:F_AM] == AM_INC;
    wire dir_rs = instr_ff[F_DIR]; // RULE19 RULE20
    wire is_pop = op_ff inside {pop_byte_op, pop_word_op, pop_doubleword_op};
    wire is_push = op_ff inside {push_byte_op, push_word_op, push_doubleword_op};
    wire is_stk = is_pop | is_push;
    wire is_b = op_ff inside {pop_byte_op, push_byte_op};
    wire is_dw = op_ff inside {pop_doubleword_op, push_doubleword_op};
    wire is_ori = op_ff == or_imm_op;
    wire is_rb = op_ff == reset_bits_byte_op;
    wire [15:0] el_sz = is_b ? 16'h0001 : is_dw ? 16'h0004 : 16'h0002;
    wire [15:0] el_addr = is_pop ? top_ff : top_ff - el_sz;
    wire [15:0] new_top = is_pop ? top_ff + el_sz : top_ff - el_sz;
    wire empty_c = top_ff == lim_ff;
    wire full_c = {1'b0, top_ff} < ({1'b0, lim_ff} + {1'b0, el_sz});
    wire stk_exc = is_pop ? empty_c : full_c; // RULE13 RULE14

    logic ins_inv, ind_inv, ind_odd, ea_inv, ea_odd, el_inv, el_odd;
    // operand span: control block for stack ops, word for OR, byte otherwise
    wire [15:0] ea_span = is_stk ? SCB_SPAN : is_ori ? 16'h0001 : 16'h0000;
    stkx_chk u_ins (.addr(iaddr_ff), .span(is_ori ? 16'h0003 : 16'h0001),
        .limit(limit_ff), .even_req(1'b0), .inv(ins_inv), .odd());
    stkx_chk u_ind (.addr(inda_ff), .span(16'h0001), .limit(limit_ff),
        .even_req(1'b1), .inv(ind_inv), .odd(ind_odd));
    stkx_chk u_ea (.addr(ea_ff), .span(ea_span), .limit(limit_ff),
        .even_req(!is_rb), .inv(ea_inv), .odd(ea_odd));
    stkx_chk u_el (.addr(el_addr), .span(el_sz - 16'h0001), .limit(limit_ff),
        .even_req(!is_b), .inv(el_inv), .odd(el_odd));
    wire chk_inv = ins_inv | (indf_ff & ind_inv) | ea_inv; // RULE17
    wire chk_spec = (indf_ff & ind_odd) | ea_odd; // RULE4 RULE18
    wire el_bad = el_inv | el_odd; // RULE17 RULE18

    // storage access sequencing
    logic m_done;
    logic [15:0] m_rd;
    wire st_rd = st_ff inside {S_SCB_TOP, S_SCB_LIM, S_RD0, S_RD1, S_OR_RD, S_RB_RD};
    wire m_we = st_ff inside {S_WR0, S_WR1, S_TOP_WR, S_OR_WR, S_RB_WR};
    wire m_go = (st_rd | m_we) & !mem_req & !m_done;
    wire [15:0] m_addr =
        st_ff == S_SCB_TOP ? ea_ff + SCB_TOP_OFS : // RULE11
        st_ff == S_SCB_LIM ? ea_ff + (is_pop ? SCB_HI_OFS : SCB_LO_OFS) :
        st_ff == S_TOP_WR ? ea_ff + SCB_TOP_OFS :
        st_ff inside {S_RD0, S_WR0} ? el_addr :
        st_ff inside {S_RD1, S_WR1} ? el_addr + 16'h0002 : ea_ff;
    wire m_byte = (st_ff inside {S_RD0, S_WR0} & is_b) | st_ff inside {S_RB_RD, S_RB_WR};
    // big-endian: even byte address is the high byte lane
    wire [1:0] m_be = !m_byte ? 2'h3 : m_addr[0] ? 2'h1 : 2'h2;
    wire [15:0] r_val = gpr_ff[r_f];
    wire [15:0] m_wd =
        st_ff == S_WR0 ? (is_b ? {r_val[7:0], r_val[7:0]} : r_val) : // RULE8 RULE10
        st_ff == S_WR1 ? gpr_ff[r_n] : // RULE9
        st_ff == S_TOP_WR ? new_top :
        st_ff == S_RB_WR ? {dhi_ff[7:0], dhi_ff[7:0]} : dhi_ff;
    wire [7:0] m_bsel = mem_addr[0] ? m_rd[7:0] : m_rd[15:8];

    stkx_mem u_mem (.hclk(hclk), .hresetn(hresetn), .go(m_go), .we(m_we),
        .addr(m_addr), .be(m_be), .wdata(m_wd), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .done(m_done), .rdata(m_rd));

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            S_IDLE: if (start) nxt_st = S_CHK;
            S_CHK: begin
                if (chk_inv | chk_spec) nxt_st = S_FIN;
                else if (is_ori) nxt_st = S_OR_RD;
                else if (is_rb) nxt_st = S_RB_RD;
                else nxt_st = S_SCB_TOP;
            end
            S_SCB_TOP: if (m_done) nxt_st = S_SCB_LIM;
            S_SCB_LIM: if (m_done) nxt_st = S_STK;
            S_STK: begin
                if (stk_exc | el_bad) nxt_st = S_FIN; // RULE22
                else if (is_pop) nxt_st = S_RD0;
                else nxt_st = S_WR0;
            end
            S_RD0: if (m_done) nxt_st = is_dw ? S_RD1 : S_TOP_WR;
            S_RD1: if (m_done) nxt_st = S_TOP_WR;
            S_WR0: if (m_done) nxt_st = is_dw ? S_WR1 : S_TOP_WR;
            S_WR1: if (m_done) nxt_st = S_TOP_WR;
            S_TOP_WR: if (m_done) nxt_st = S_FIN;
            S_OR_RD: if (m_done) nxt_st = S_OR_WR;
            S_OR_WR: if (m_done) nxt_st = S_FIN;
            S_RB_RD: if (m_done) nxt_st = dir_rs ? S_RB_WR : S_FIN; // RULE19
            S_RB_WR: if (m_done) nxt_st = S_FIN;
            S_FIN: nxt_st = S_IDLE;
            default: nxt_st = S_IDLE;
        endcase
    end

    wire ev_inv = (st_ff == S_CHK & chk_inv) | (st_ff == S_STK & !stk_exc & el_inv);
    wire ev_spec = (st_ff == S_CHK & !chk_inv & chk_spec) |
        (st_ff == S_STK & !stk_exc & !el_inv & el_odd);
    wire fin = st_ff == S_FIN;
    wire fin_ok = fin & !inv_ff & !spec_ff & !stk_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= S_IDLE;
            busy_ff <= 1'b0;
            trap_ff <= 1'b0;
            pchk_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            busy_ff <= nxt_st != S_IDLE;
            trap_ff <= fin & stk_ff; // RULE13 RULE14
            pchk_ff <= fin & (inv_ff | spec_ff);
        end
    end
    assign busy = busy_ff;
    assign soft_trap = trap_ff;
    assign prog_check = pchk_ff;

    // status flags clear only at start, which never meets a set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_ff <= 1'b0;
            stk_ff <= 1'b0;
            inv_ff <= 1'b0;
            spec_ff <= 1'b0;
        end else begin
            done_ff <= fin | (done_ff & !start);
            stk_ff <= (st_ff == S_STK & stk_exc) | (stk_ff & !start);
            inv_ff <= ev_inv | (inv_ff & !start);
            spec_ff <= ev_spec | (spec_ff & !start);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            top_ff <= 16'h0000;
            lim_ff <= 16'h0000;
            dhi_ff <= 16'h0000;
            dlo_ff <= 16'h0000;
        end else if (m_done) begin
            if (st_ff == S_SCB_TOP) top_ff <= m_rd;
            if (st_ff == S_SCB_LIM) lim_ff <= m_rd;
            if (st_ff == S_RD0) dhi_ff <= is_b ? {8'h00, m_bsel} : m_rd; // RULE5 RULE7
            if (st_ff == S_RD1) dlo_ff <= m_rd;
            if (st_ff == S_OR_RD) dhi_ff <= m_rd | imm_ff; // RULE1
            if (st_ff == S_RB_RD) dhi_ff <= {8'h00, dir_rs ?
                m_bsel & ~r_val[7:0] : r_val[7:0] & ~m_bsel}; // RULE21
        end
    end

    // register results commit only at the end; a trap leaves all of them but the base step untouched
    wire pop_wr = fin_ok & is_pop; // RULE22
    wire rb_wr = fin_ok & is_rb & !dir_rs; // RULE21
    wire base_wr = fin & is_stk & am_inc & !inv_ff & !spec_ff; // RULE12 RULE15
    wire res_neg = is_ori ? dhi_ff[15] : dhi_ff[7];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 8; i++) gpr_ff[i] <= 16'h0000;
        end else begin
            if (sw_gpr) gpr_ff[wa_ff[4:2]] <= hwdata[15:0];
            if (pop_wr) gpr_ff[r_f] <= is_b ? {r_val[15:8], dhi_ff[7:0]} : dhi_ff;
            if (pop_wr & is_dw) gpr_ff[r_n] <= dlo_ff; // RULE6
            if (rb_wr) gpr_ff[r_f][7:0] <= dhi_ff[7:0];
            if (base_wr) gpr_ff[rb_f] <= gpr_ff[rb_f] + BASE_STEP; // RULE12
        end
    end

    // carry and overflow never touched by the sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ind_ff <= 5'h00;
        end else if (sw & wa_ff == A_IND) begin
            ind_ff <= hwdata[4:0];
        end else if (fin_ok & (is_ori | is_rb)) begin // RULE16
            ind_ff[I_EVEN] <= !dhi_ff[0]; // RULE3
            ind_ff[I_NEG] <= res_neg;
            ind_ff[I_ZERO] <= dhi_ff == 16'h0000;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_empty;
        st_ff == S_STK && is_pop && empty_c;
    endsequence
    sequence s_full;
        st_ff == S_STK && is_push && full_c;
    endsequence
    sequence s_trap_out;
        st_ff == S_FIN ##1 soft_trap;
    endsequence

    property p_ori_or;
        st_ff == S_OR_RD && m_done |=> dhi_ff == ($past(m_rd) | imm_ff);
    endproperty
    a_ori_or: assert property (p_ori_or) else $error("or result wrong"); // RULE1

    property p_ori_ind;
        fin_ok && is_ori |=> ind_ff[I_ZERO] == (dhi_ff == 16'h0000) &&
            ind_ff[I_NEG] == dhi_ff[15] && $stable(ind_ff[I_CARRY]) &&
            $stable(ind_ff[I_OVF]);
    endproperty
    a_ori_ind: assert property (p_ori_ind) else $error("or indicators wrong"); // RULE3

    property p_ori_spec;
        st_ff == S_CHK && is_ori && ea_odd && !chk_inv |=> spec_ff && st_ff == S_FIN;
    endproperty
    a_ori_spec: assert property (p_ori_spec) else $error("odd operand missed"); // RULE4

    property p_pop_empty;
        s_empty |=> s_trap_out;
    endproperty
    a_pop_empty: assert property (p_pop_empty) else $error("empty trap missing"); // RULE13

    property p_push_full;
        s_full |=> s_trap_out;
    endproperty
    a_push_full: assert property (p_push_full) else $error("full trap missing"); // RULE14

    property p_base_inc;
        fin && stk_ff && am_inc |=> gpr_ff[rb_f] == $past(gpr_ff[rb_f]) + BASE_STEP;
    endproperty
    a_base_inc: assert property (p_base_inc) else $error("base not stepped"); // RULE15

    property p_ind_hold;
        busy_ff && is_stk |=> $stable(ind_ff);
    endproperty
    a_ind_hold: assert property (p_ind_hold) else $error("indicators moved"); // RULE16

    property p_dw_pair;
        fin_ok && op_ff == pop_doubleword_op && rb_f != r_f && rb_f != r_n |=>
            gpr_ff[r_f] == $past(dhi_ff) && gpr_ff[r_n] == $past(dlo_ff);
    endproperty
    a_dw_pair: assert property (p_dw_pair) else $error("pair load wrong"); // RULE6

    property p_trap_quiet;
        st_ff == S_STK && stk_exc |=> !mem_req [*2];
    endproperty
    a_trap_quiet: assert property (p_trap_quiet) else $error("write after trap"); // RULE22
endmodule
`default_nettype wire

// ===== testbench/stkx_store_model.sv
/*
 * Main storage model: byte array behind the storage request link.
 * Assumes requests held until ack; ack comes at once or after 3 waits.
 */
`timescale 1ns/1ps
`default_nettype none
module stkx_store_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [1:0] mem_be,
    input wire logic [15:0] mem_wdata,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_ff;
    wire [15:0] ev = {mem_addr[15:1], 1'b0};
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_ack <= 1'b0;
            wait_ff <= 2'h0;
            mem_rdata <= 16'hFFFF;
        end else if (mem_req && !mem_ack && (wait_ff == 2'h3 || !slow)) begin
            mem_ack <= 1'b1;
            wait_ff <= 2'h0;
            mem_rdata <= {mem[ev], mem[ev | 16'h0001]};
            if (mem_we && mem_be[1])
                mem[ev] <= mem_wdata[15:8];
            if (mem_we && mem_be[0])
                mem[ev | 16'h0001] <= mem_wdata[7:0];
        end else begin
            mem_ack <= 1'b0;
            wait_ff <= (mem_req && !mem_ack) ? wait_ff + 2'h1 : 2'h0;
            // idle bus inverts the data each cycle, so stale data never holds steady
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/stkx_top_tb.sv
/*
 * Self-checking bench: table of instructions, then fault cases.
 * Assumes the storage model above and zero-wait bus slave.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got=%0h exp=%0h", $time, (g), (e)); end end
module stkx_top_tb;
    import stkx_pkg::*;
    typedef struct {stkx_op_e op; logic [31:0] ins; logic [15:0] ea; logic [2:0] g;
        logic [15:0] gexp, ma, mexp, texp; logic [4:0] iexp;} stkx_row_s;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0] htrans = 2'h0, mem_be;
    logic [2:0] hsize = 3'h0;
    logic hreadyout, hresp, mem_req, mem_we, mem_ack, busy, soft_trap, prog_check;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    int err_total = 0, check_count = 0, trap_n = 0, pchk_n = 0;
    // stack control block at 0100: high 0220, low 0200, top 0210
    stkx_row_s rows [11] = '{
        '{pop_byte_op,32'h0200,16'h0100,3'h2,16'h5AA1,16'h0210,16'hA1B2,16'h0211,5'h19},
        '{pop_word_op,32'h0300,16'h0100,3'h3,16'hA1B2,16'h0210,16'hA1B2,16'h0212,5'h19},
        '{pop_doubleword_op,32'h0740,16'h0100,3'h7,16'hA1B2,16'h0212,16'hC3D4,16'h0214,5'h19},
        '{pop_doubleword_op,32'h0740,16'h0100,3'h0,16'hC3D4,16'h0212,16'hC3D4,16'h0214,5'h19},
        '{push_byte_op,32'h0150,16'h0100,3'h1,16'h5A33,16'h020E,16'h0031,16'h020F,5'h19},
        '{push_word_op,32'h0400,16'h0100,3'h4,16'h5A34,16'h020E,16'h5A34,16'h020E,5'h19},
        '{push_doubleword_op,32'h0700,16'h0100,3'h7,16'h5A37,16'h020C,16'h5A37,16'h020C,5'h19},
        '{push_doubleword_op,32'h0700,16'h0100,3'h0,16'h5A30,16'h020E,16'h5A30,16'h020C,5'h19},
        // reserved bits kept zero
        '{or_imm_op,32'h80000000,16'h0300,3'h0,16'h5A30,16'h0300,16'h8F00,16'h000F,5'h1E},
        '{reset_bits_byte_op,32'h0500,16'h0305,3'h5,16'h5A30,16'h0304,16'h000F,16'h0,5'h1C},
        '{reset_bits_byte_op,32'h0508,16'h0305,3'h5,16'h5A35,16'h0304,16'h000A,16'h0,5'h1C}};
    always #25 hclk = ~hclk;
    stkx_top stkx_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req, .mem_we,
        .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata, .busy, .soft_trap,
        .prog_check);
    stkx_store_model stkx_store_model_inst (.hclk, .hresetn, .slow, .mem_req, .mem_we,
        .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata);
    always @(posedge hclk) begin
        if (soft_trap === 1'b1) trap_n++;
        if (prog_check === 1'b1) pchk_n++;
    end
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ahb(1'b1, a, v, d);
    endtask
    task automatic put(input logic [15:0] a, input logic [15:0] v);
        stkx_store_model_inst.mem[a] = v[15:8];
        stkx_store_model_inst.mem[a + 16'h1] = v[7:0];
    endtask
    function automatic logic [15:0] getw(input logic [15:0] a);
        return {stkx_store_model_inst.mem[a], stkx_store_model_inst.mem[a + 16'h1]};
    endfunction
    task automatic prep(input logic sl);
        slow <= sl;
        put(16'h0100, 16'h0220);
        put(16'h0102, 16'h0200);
        put(16'h0104, 16'h0210);
        put(16'h0210, 16'hA1B2);
        put(16'h0212, 16'hC3D4);
        put(16'h020C, 16'h0000);
        put(16'h020E, 16'h0000);
        put(16'h0300, 16'h0F00);
        put(16'h0304, 16'h000F);
        for (int n = 0; n < 8; n++) wr(A_GPR + 8'(4 * n), 32'h5A30 + n);
        // carry, overflow, zero preset so untouched flags show
        wr(A_IND, 32'h19);
    endtask
    task automatic run(input stkx_op_e op, input logic [31:0] ins, input logic [15:0] ea,
            input logic [15:0] ia = 16'h0000);
        int n;
        wr(A_INSTR, ins);
        wr(A_EADDR, {ia, ea});
        // nonzero indirect address turns the indirect flag on
        wr(A_CTRL, {25'h0, op, 2'h0, ia != 16'h0000, 1'b1});
        n = 0;
        #1;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge hclk);
            #1;
            n++;
        end
        if (n == 400) err_total++;
        ahb(1'b0, A_STAT, 32'h0, d);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        final_report;
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, A_STAT, 32'h0, d);
        `CHK(d, 32'h0)
        ahb(1'b0, A_LIMIT, 32'h0, d);
        `CHK(d, 32'hFFFF)
        ahb(1'b0, 8'h40, 32'h0, d);
        `CHK(d, 32'h0)
        `CHK(hresp, 1'b0)
        foreach (rows[i]) begin
            prep(i[0]);
            run(rows[i].op, rows[i].ins, rows[i].ea);
            `CHK(d, 32'h2)
            ahb(1'b0, A_GPR + {3'h0, rows[i].g, 2'h0}, 32'h0, d);
            `CHK(d[15:0], rows[i].gexp)
            `CHK(getw(rows[i].ma), rows[i].mexp)
            `CHK(getw((rows[i].ea + 16'h4) & 16'hFFFE), rows[i].texp)
            ahb(1'b0, A_IND, 32'h0, d);
            `CHK(d[4:0], rows[i].iexp)
        end
        // empty pop, base register 1 stepped
        prep(1'b0);
        put(16'h0104, 16'h0220);
        run(pop_word_op, 32'h0350, 16'h0100);
        `CHK(d, 32'h6)
        ahb(1'b0, A_GPR + 8'h4, 32'h0, d);
        `CHK(d[15:0], 16'h5A33)
        ahb(1'b0, A_GPR + 8'hC, 32'h0, d);
        `CHK(d[15:0], 16'h5A33)
        `CHK(getw(16'h0104), 16'h0220)
        // full push with slow storage, mode 00 leaves base alone
        prep(1'b1);
        put(16'h0104, 16'h0200);
        run(push_word_op, 32'h0480, 16'h0100);
        `CHK(d, 32'h6)
        ahb(1'b0, A_GPR + 8'h8, 32'h0, d);
        `CHK(d[15:0], 16'h5A32)
        `CHK(getw(16'h0104), 16'h0200)
        `CHK(trap_n, 2)
        run(pop_word_op, 32'h0300, 16'h0101);
        `CHK(d, 32'h12)
        run(or_imm_op, 32'h80000000, 16'h0301);
        `CHK(d, 32'h12)
        // odd indirect address
        run(pop_word_op, 32'h0300, 16'h0100, 16'h0103);
        `CHK(d, 32'h12)
        wr(A_LIMIT, 32'hFF);
        run(pop_word_op, 32'h0300, 16'h0100);
        `CHK(d, 32'hA)
        // instruction word past the top of storage
        wr(A_IADDR, 32'hFF);
        run(pop_word_op, 32'h0300, 16'h0010);
        `CHK(d, 32'hA)
        `CHK(pchk_n, 5)
        final_report;
    end
endmodule
`default_nettype wire
